// ### rtl/wmo_output_ctrl.sv
// Purpose: code for an unpowered analog output in warm-up or monitor mode
// Assumes: readings arrive on core_clk; non-volatile state comes from
//          a same-clock store, valid in the first cycle after reset
// Notes:   output code is signed millivolts held in a flip-flop
//
// Function
// - warm-up drive is ten volts times fraction
// - fraction limited 0..100 percent, default 100
// - auto-off: drive to setpoint, then clear range
// - range on again restarts auto-off cycle
// - continuous: off at setpoint, on 1 K below
// - continuous mode never clears range itself
// - feedback input selects warm-up temperature
// - power-up enable decides range after power cycle
// - monitor tracks selected input, none or four
// - monitor output ignores global all-off command
// - units select kelvin, celsius or sensor value
// - polarity picks unipolar or bipolar span
// - bipolar: negative endpoint gives minus ten volts
// - unipolar: zero endpoint gives zero volts
// - positive endpoint gives plus ten volts
// - reset: unipolar, 0 K, 0 K, 1000 K endpoints
// - endpoints limited to range of current units
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module wmo_output_ctrl
    import wmo_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    input  wire wmo_pkg::wmo_reading_t reading [4],
    input  wire logic                 nv_range_on,
    input  wire logic                 nv_pu_en,
    output logic                      range_on,
    output logic                      pu_en,
    output logic signed [15:0]        dac_mv,
    output logic                      out_enabled
);
    import wmo_pkg::*;

    // limit an endpoint to what the chosen units allow
    function automatic logic signed [31:0] clamp_ep(
        input logic signed [31:0] v,
        input wmo_units_t         u
    );
        logic signed [31:0] lo;
        lo = (u == UNITS_C) ? EP_MIN_C :
             (u == UNITS_SENSOR) ? EP_MIN_S : EP_MIN_K;
        if (v < lo) begin
            clamp_ep = lo;
        end else if (v > EP_MAX) begin
            clamp_ep = EP_MAX;
        end else begin
            clamp_ep = v;
        end
    endfunction : clamp_ep

    // pick one unit field of a reading
    function automatic logic signed [31:0] pick_units(
        input wmo_reading_t r,
        input wmo_units_t   u
    );
        case (u)
            UNITS_C:      pick_units = r.celsius;
            UNITS_SENSOR: pick_units = r.sensor;
            default:      pick_units = r.kelvin;
        endcase
    endfunction : pick_units

    wmo_cfg_t           cfg;
    wmo_cfg_t           next_cfg;
    wmo_wu_state_t      wu_state;
    wmo_wu_state_t      next_wu_state;
    logic               booted;
    logic               next_booted;
    logic signed [15:0] next_dac_mv;
    logic [31:0]        next_reg_rdata;
    logic               drive_on;
    logic               in_valid;
    logic signed [31:0] fb_k;
    logic signed [31:0] mon_val;
    logic               at_setpt;
    logic               below_hyst;
    logic signed [15:0] warm_mv;
    logic signed [15:0] mon_mv;
    logic signed [31:0] ep_lo;
    logic signed [15:0] lo_mv;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [63:0] quo;
    logic signed [63:0] lin;
    logic [31:0]        wr_ctrl;
    logic [6:0]         wr_pct;

    // feedback and tracked reading from the selected input
    always_comb begin
        in_valid = (cfg.insel >= 3'h1) && (cfg.insel <= 3'h4);
        fb_k     = 32'sh0000_0000;
        mon_val  = 32'sh0000_0000;
        if (in_valid) begin
            fb_k    = reading[cfg.insel[1:0] - 2'h1].kelvin;
            mon_val = pick_units(reading[cfg.insel[1:0] - 2'h1],
                                 cfg.units);
        end
        at_setpt   = in_valid && (fb_k >= cfg.setpt);
        // no input selected: never reaches setpoint, drive simply holds
        below_hyst = in_valid && (fb_k <= cfg.setpt - HYST_COUNTS);
    end

    // warm-up level: percent times 100 mV gives percent of 10 V
    always_comb begin
        warm_mv = signed'(16'(cfg.wpct) * MV_PER_PCT);
    end

    // monitor mapping; division keeps endpoints free but costs area
    always_comb begin
        ep_lo = cfg.bipolar ? cfg.mneg : cfg.mzero;
        lo_mv = cfg.bipolar ? NEG_FS_MV : 16'sh0000;
        num   = 64'(mon_val) - 64'(ep_lo);
        den   = 64'(cfg.mpos) - 64'(ep_lo);
        quo   = 64'sh0;
        if (den != 64'sh0) begin
            quo = (num * (64'(FS_MV) - 64'(lo_mv))) / den;
            lin = 64'(lo_mv) + quo;
        end else begin
            // degenerate span: step at the shared endpoint
            lin = (mon_val >= cfg.mpos) ? 64'(FS_MV) : 64'(lo_mv);
        end
        if (lin > 64'(FS_MV)) begin
            mon_mv = FS_MV;
        end else if (lin < 64'(lo_mv)) begin
            mon_mv = lo_mv;
        end else begin
            mon_mv = lin[15:0];
        end
        if (!in_valid) begin
            mon_mv = 16'sh0000;
        end
    end

    // configuration, warm-up sequencing and read-back
    always_comb begin
        next_cfg       = cfg;
        next_wu_state  = wu_state;
        next_booted    = 1'b1;
        next_reg_rdata = 32'h0000_0000;
        wr_ctrl        = reg_wdata;
        wr_pct         = reg_wdata[6:0];

        // restore range once after a power cycle
        if (!booted) begin
            next_cfg.pu_en    = nv_pu_en;
            next_cfg.range_on = nv_range_on & nv_pu_en;
        end

        // warm-up control loop
        case (wu_state)
            WU_IDLE: begin
                if (cfg.mode == MODE_WARMUP && cfg.range_on) begin
                    next_wu_state = WU_DRIVE;
                end
            end
            WU_DRIVE: begin
                if (at_setpt) begin
                    if (cfg.continuous) begin
                        next_wu_state = WU_HOLD;
                    end else begin
                        next_wu_state     = WU_IDLE;
                        next_cfg.range_on = 1'b0;
                    end
                end
            end
            WU_HOLD: begin
                if (!cfg.continuous) begin
                    next_wu_state     = WU_IDLE;
                    next_cfg.range_on = 1'b0;
                end else if (below_hyst) begin
                    next_wu_state = WU_DRIVE;
                end
            end
            default: begin
                next_wu_state = WU_IDLE;
            end
        endcase
        if (cfg.mode != MODE_WARMUP || !cfg.range_on) begin
            next_wu_state = WU_IDLE;
        end

        // software writes come last so a fresh on wins over auto-off
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: begin
                    next_cfg.mode       = wmo_mode_t'(wr_ctrl[CTRL_MODE_LSB +: 2]);
                    next_cfg.insel      = wr_ctrl[CTRL_INSEL_LSB +: 3];
                    next_cfg.units      = wmo_units_t'(wr_ctrl[CTRL_UNITS_LSB +: 2]);
                    next_cfg.bipolar    = wr_ctrl[CTRL_POL_BIT];
                    next_cfg.continuous = wr_ctrl[CTRL_WCTL_BIT];
                    next_cfg.pu_en      = wr_ctrl[CTRL_PUEN_BIT];
                    // endpoints follow a change of units
                    next_cfg.mneg  = clamp_ep(cfg.mneg, next_cfg.units);
                    next_cfg.mzero = clamp_ep(cfg.mzero, next_cfg.units);
                    next_cfg.mpos  = clamp_ep(cfg.mpos, next_cfg.units);
                end
                OFS_RANGE: next_cfg.range_on = reg_wdata[0];
                OFS_WPCT: begin
                    // compare the whole word: a low-bit slice of 200 looks legal
                    next_cfg.wpct = (reg_wdata > 32'(WPCT_MAX)) ?
                                    WPCT_MAX : wr_pct;
                end
                OFS_SETPT: next_cfg.setpt = signed'(reg_wdata);
                OFS_MNEG:  next_cfg.mneg  = clamp_ep(signed'(reg_wdata), cfg.units);
                OFS_MZERO: next_cfg.mzero = clamp_ep(signed'(reg_wdata), cfg.units);
                OFS_MPOS:  next_cfg.mpos  = clamp_ep(signed'(reg_wdata), cfg.units);
                OFS_ALLOFF: begin
                    // monitor has no range; its output stays untouched
                    next_cfg.range_on = 1'b0;
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    next_reg_rdata[CTRL_MODE_LSB +: 2]  = cfg.mode;
                    next_reg_rdata[CTRL_INSEL_LSB +: 3] = cfg.insel;
                    next_reg_rdata[CTRL_UNITS_LSB +: 2] = cfg.units;
                    next_reg_rdata[CTRL_POL_BIT]        = cfg.bipolar;
                    next_reg_rdata[CTRL_WCTL_BIT]       = cfg.continuous;
                    next_reg_rdata[CTRL_PUEN_BIT]       = cfg.pu_en;
                end
                OFS_RANGE:  next_reg_rdata[0]   = cfg.range_on;
                OFS_WPCT:   next_reg_rdata[6:0] = cfg.wpct;
                OFS_SETPT:  next_reg_rdata = cfg.setpt;
                OFS_MNEG:   next_reg_rdata = cfg.mneg;
                OFS_MZERO:  next_reg_rdata = cfg.mzero;
                OFS_MPOS:   next_reg_rdata = cfg.mpos;
                OFS_STATUS: begin
                    next_reg_rdata[15:0]           = dac_mv;
                    next_reg_rdata[STAT_DRIVE_BIT] = drive_on;
                    next_reg_rdata[STAT_EN_BIT]    = out_enabled;
                end
                default: begin
                end
            endcase
        end
    end

    // output code selection by mode
    always_comb begin
        drive_on    = (wu_state == WU_DRIVE) && cfg.range_on;
        next_dac_mv = 16'sh0000;
        case (cfg.mode)
            MODE_MONITOR: next_dac_mv = mon_mv;
            MODE_WARMUP:  next_dac_mv = drive_on ? warm_mv : 16'sh0000;
            default:      next_dac_mv = 16'sh0000;
        endcase
    end

    assign out_enabled = (cfg.mode == MODE_MONITOR) ||
                         (cfg.mode == MODE_WARMUP && cfg.range_on);
    assign range_on    = cfg.range_on;
    assign pu_en       = cfg.pu_en;

    // state registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg.mode       <= MODE_OFF;
            cfg.insel      <= RST_INSEL;
            cfg.units      <= UNITS_K;
            cfg.bipolar    <= RST_POL;
            cfg.continuous <= RST_CONT;
            cfg.pu_en      <= 1'b0;
            cfg.range_on   <= 1'b0;
            cfg.wpct       <= RST_WPCT;
            cfg.setpt      <= RST_SETPT;
            cfg.mneg       <= RST_MNEG;
            cfg.mzero      <= RST_MZERO;
            cfg.mpos       <= RST_MPOS;
            wu_state       <= WU_IDLE;
            booted         <= 1'b0;
            dac_mv         <= 16'sh0000;
            reg_rdata      <= 32'h0000_0000;
        end else begin
            cfg       <= next_cfg;
            wu_state  <= next_wu_state;
            booted    <= next_booted;
            dac_mv    <= next_dac_mv;
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule : wmo_output_ctrl

`default_nettype wire

// ### rtl/wmo_pkg.sv
// Purpose: shared constants and types for the warm-up / monitor output block
// Assumes: readings and endpoints are signed counts of 0.0001 unit
// Notes:   output code is signed millivolts, +10 V full scale
package wmo_pkg;

    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RANGE  = 8'h04;
    localparam logic [7:0] OFS_WPCT   = 8'h08;
    localparam logic [7:0] OFS_SETPT  = 8'h0C;
    localparam logic [7:0] OFS_MNEG   = 8'h10;
    localparam logic [7:0] OFS_MZERO  = 8'h14;
    localparam logic [7:0] OFS_MPOS   = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_ALLOFF = 8'h20;

    // control and status register field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_INSEL_LSB = 2;
    localparam int CTRL_UNITS_LSB = 5;
    localparam int CTRL_POL_BIT   = 7;
    localparam int CTRL_WCTL_BIT  = 8;
    localparam int CTRL_PUEN_BIT  = 9;
    localparam int STAT_DRIVE_BIT = 16;
    localparam int STAT_EN_BIT    = 17;

    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_MONITOR = 2'h1,
        MODE_WARMUP  = 2'h2
    } wmo_mode_t;

    typedef enum logic [1:0] {
        UNITS_K      = 2'h0,
        UNITS_C      = 2'h1,
        UNITS_SENSOR = 2'h2
    } wmo_units_t;

    // warm-up states, gray along idle -> drive -> hold
    typedef enum logic [1:0] {
        WU_IDLE  = 2'h0,
        WU_DRIVE = 2'h1,
        WU_HOLD  = 2'h3
    } wmo_wu_state_t;

    typedef struct packed {
        logic signed [31:0] kelvin;
        logic signed [31:0] celsius;
        logic signed [31:0] sensor;
    } wmo_reading_t;

    typedef struct packed {
        wmo_mode_t          mode;
        logic [2:0]         insel;
        wmo_units_t         units;
        logic               bipolar;
        logic               continuous;
        logic               pu_en;
        logic               range_on;
        logic [6:0]         wpct;
        logic signed [31:0] setpt;
        logic signed [31:0] mneg;
        logic signed [31:0] mzero;
        logic signed [31:0] mpos;
    } wmo_cfg_t;

    // reset values
    localparam logic [2:0]         RST_INSEL = 3'h0;
    localparam logic [6:0]         RST_WPCT  = 7'h64;
    localparam logic               RST_CONT  = 1'b1;
    localparam logic               RST_POL   = 1'b0;
    localparam logic signed [31:0] RST_SETPT = 32'sh0000_0000;
    localparam logic signed [31:0] RST_MNEG  = 32'sh0000_0000;
    localparam logic signed [31:0] RST_MZERO = 32'sh0000_0000;
    localparam logic signed [31:0] RST_MPOS  = 32'sh0098_9680;

    // limits and scale
    localparam logic [6:0]         WPCT_MAX    = 7'h64;
    localparam logic signed [31:0] EP_MAX      = 32'sh05F5_E0FF;
    localparam logic signed [31:0] EP_MIN_K    = 32'sh0000_0000;
    localparam logic signed [31:0] EP_MIN_C    = 32'shFFD6_5214;
    localparam logic signed [31:0] EP_MIN_S    = 32'sh0000_0000;
    localparam logic signed [31:0] HYST_COUNTS = 32'sh0000_2710;
    localparam logic signed [15:0] FS_MV       = 16'sh2710;
    localparam logic signed [15:0] NEG_FS_MV   = 16'shD8F0;
    localparam logic [15:0]        MV_PER_PCT  = 16'h0064;

endpackage : wmo_pkg

// ### tb/tb_top.sv
// Purpose: self-checking bench for the warm-up / monitor output block
// Assumes: 20 MHz clock, reset held twelve cycles
// Notes:   the output level is judged through the sink model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import wmo_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic               nv_range_on = 1'b0;
    logic               nv_pu_en = 1'b0;
    logic [31:0]        reg_rdata;
    logic               range_on;
    logic               pu_en;
    logic               out_enabled;
    logic signed [15:0] dac_mv;
    logic signed [15:0] seen_mv;
    wmo_reading_t       rdg [4];
    int                 failures = 0;
    int                 comparisons = 0;

    always #25 core_clk = ~core_clk;

    wmo_output_ctrl i_dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reading(rdg),
        .nv_range_on(nv_range_on), .nv_pu_en(nv_pu_en),
        .range_on(range_on), .pu_en(pu_en), .dac_mv(dac_mv),
        .out_enabled(out_enabled));
    wmo_ext_sink i_sink (.core_clk(core_clk), .dac_mv(dac_mv),
        .seen_mv(seen_mv));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // strobe low for a cycle after each write, so no double drive
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, exp);
        @(posedge core_clk);
    endtask : chk_rd

    // waits past the pipeline plus the sink lag, then judges seen level, range and enable
    task automatic chk_out(input logic [15:0] mv, input logic rng,
                           input logic en);
        repeat (5) @(posedge core_clk);
        #1 cmp({14'h0, range_on, out_enabled, seen_mv}, {14'h0, rng, en, mv});
        @(posedge core_clk);
    endtask : chk_out

    task automatic set_in(input int i, input logic [31:0] k, c, s);
        rdg[i] <= {k, c, s};
    endtask : set_in

    task automatic do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    task automatic t_defaults;
        chk_rd(OFS_WPCT, 32'h64);
        chk_rd(OFS_MNEG, 32'h0);
        chk_rd(OFS_MZERO, 32'h0);
        chk_rd(OFS_MPOS, 32'h0098_9680);
        chk_rd(8'h24, 32'h0);
        wr(OFS_WPCT, 32'hC8);
        chk_rd(OFS_WPCT, 32'h64);
    endtask : t_defaults

    task automatic t_warm_cont;
        set_in(0, 32'hC350, 32'h0, 32'h0);
        set_in(1, 32'h30D40, 32'h0, 32'h0);
        wr(OFS_WPCT, 32'h32);
        wr(OFS_SETPT, 32'h186A0);
        wr(OFS_CTRL, 32'h106);
        chk_rd(OFS_CTRL, 32'h106);
        chk_rd(OFS_SETPT, 32'h186A0);
        wr(OFS_RANGE, 32'h1);
        chk_out(16'h1388, 1'b1, 1'b1);
        chk_rd(OFS_STATUS, 32'h0003_1388);
        set_in(0, 32'h186A0, 32'h0, 32'h0);
        chk_out(16'h0, 1'b1, 1'b1);
        chk_rd(OFS_STATUS, 32'h0002_0000);
        chk_rd(OFS_RANGE, 32'h1);
        set_in(0, 32'h15F91, 32'h0, 32'h0);
        chk_out(16'h0, 1'b1, 1'b1);
        set_in(0, 32'h15F90, 32'h0, 32'h0);
        chk_out(16'h1388, 1'b1, 1'b1);
    endtask : t_warm_cont

    task automatic t_warm_auto;
        wr(OFS_CTRL, 32'h006);
        set_in(0, 32'h186A0, 32'h0, 32'h0);
        chk_out(16'h0, 1'b0, 1'b0);
        set_in(0, 32'hC350, 32'h0, 32'h0);
        chk_out(16'h0, 1'b0, 1'b0);
        wr(OFS_WPCT, 32'h64);
        wr(OFS_RANGE, 32'h1);
        chk_out(FS_MV, 1'b1, 1'b1);
        wr(OFS_WPCT, 32'h0);
        chk_out(16'h0, 1'b1, 1'b1);
        // the restarted cycle must end at the setpoint as the first did
        set_in(0, 32'h186A0, 32'h0, 32'h0);
        chk_out(16'h0, 1'b0, 1'b0);
        set_in(0, 32'hC350, 32'h0, 32'h0);
        wr(OFS_RANGE, 32'h1);
        wr(OFS_ALLOFF, 32'h1);
        chk_out(16'h0, 1'b0, 1'b0);
        wr(OFS_CTRL, 32'h3);
        chk_out(16'h0, 1'b0, 1'b0);
    endtask : t_warm_auto

    task automatic t_monitor;
        wr(OFS_CTRL, 32'h005);
        wr(OFS_MPOS, 32'hF4240);
        set_in(0, 32'h7A120, 32'h0, 32'h0);
        chk_out(16'h1388, 1'b0, 1'b1);
        set_in(0, 32'h0, 32'h0, 32'h0);
        chk_out(16'h0, 1'b0, 1'b1);
        set_in(0, 32'h1E8480, 32'h0, 32'h0);
        chk_out(FS_MV, 1'b0, 1'b1);
        wr(OFS_CTRL, 32'h085);
        set_in(0, 32'h0, 32'h0, 32'h0);
        chk_out(NEG_FS_MV, 1'b0, 1'b1);
        set_in(0, 32'h7A120, 32'h0, 32'h0);
        chk_out(16'h0, 1'b0, 1'b1);
        set_in(0, 32'hF4240, 32'h0, 32'h0);
        wr(OFS_ALLOFF, 32'h1);
        chk_out(FS_MV, 1'b0, 1'b1);
        wr(OFS_CTRL, 32'h0A5);
        wr(OFS_MNEG, 32'hFA0A_1F01);
        chk_rd(OFS_MNEG, 32'hFFD6_5214);
        set_in(0, 32'h0, 32'hFFD6_5214, 32'h0);
        chk_out(NEG_FS_MV, 1'b0, 1'b1);
        wr(OFS_CTRL, 32'h0C5);
        chk_rd(OFS_MNEG, 32'h0);
        // each input in turn, sensor units, unipolar
        for (int i = 0; i < 4; i++) begin
            set_in(i, 32'h0, 32'h0, 32'(32'h186A0 * (i + 1)));
            wr(OFS_CTRL, 32'(32'h41 + 4 * (i + 1)));
            chk_out(16'(32'h3E8 * (i + 1)), 1'b0, 1'b1);
        end
        wr(OFS_CTRL, 32'h041);
        chk_out(16'h0, 1'b0, 1'b1);
    endtask : t_monitor

    task automatic t_restore;
        nv_range_on <= 1'b1;
        nv_pu_en <= 1'b1;
        do_reset;
        cmp({30'h0, pu_en, range_on}, 32'h3);
        nv_pu_en <= 1'b0;
        do_reset;
        cmp({30'h0, pu_en, range_on}, 32'h0);
    endtask : t_restore

    task automatic summarize;
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        for (int i = 0; i < 4; i++) rdg[i] = '0;
        do_reset;
        t_defaults;
        t_warm_cont;
        t_warm_auto;
        t_monitor;
        t_restore;
        summarize;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        summarize;
    end
endmodule : tb_top
`default_nettype wire

// ### tb/wmo_ext_sink.sv
// Purpose: external supply or acquisition input on the analog output
// Assumes: the output code is settled at each rising edge
// Notes:   samples once per clock, so it lags the block by one cycle
`timescale 1ns/10ps
`default_nettype none
module wmo_ext_sink (
    input  wire logic               core_clk,
    input  wire logic signed [15:0] dac_mv,
    output logic signed [15:0]      seen_mv
);
    // the far side only ever listens, it never loads the code
    always_ff @(posedge core_clk) begin
        seen_mv <= dac_mv;
    end
endmodule : wmo_ext_sink
`default_nettype wire

// ### tb/wmo_output_ctrl_monitor.sv
// Purpose: port-level checks for the warm-up / monitor output block
// Assumes: one clock, asynchronous active-high reset
// Notes:   the continuous bit is shadowed here from the register writes
`timescale 1ns/10ps
`default_nettype none
module wmo_output_ctrl_monitor
    import wmo_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic [7:0]            reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    input wire wmo_pkg::wmo_reading_t reading [4],
    input wire logic                  nv_range_on,
    input wire logic                  nv_pu_en,
    input wire logic                  range_on,
    input wire logic                  pu_en,
    input wire logic signed [15:0]    dac_mv,
    input wire logic                  out_enabled
);
    import wmo_pkg::*;
    logic cont;
    logic next_cont;
    logic sw_rng;

    // writes that may legally move the range setting
    assign sw_rng = reg_wr && (reg_addr == OFS_RANGE
        || reg_addr == OFS_ALLOFF || reg_addr == OFS_CTRL);

    // shadow of the continuous bit, hidden from the ports otherwise
    always_comb begin
        next_cont = cont;
        if (reg_wr && reg_addr == OFS_CTRL)
            next_cont = reg_wdata[CTRL_WCTL_BIT];
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cont <= RST_CONT;
        else cont <= next_cont;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_warm_off;
        !out_enabled [*3] |-> dac_mv == 16'sh0;
    endproperty
    property p_cont_keep;
        cont && range_on && !sw_rng |=> range_on;
    endproperty
    property p_range_set;
        reg_wr && reg_addr == OFS_RANGE && reg_wdata[0] |=> range_on;
    endproperty
    property p_mon_alloff;
        out_enabled && !range_on && reg_wr && reg_addr == OFS_ALLOFF
            |=> out_enabled;
    endproperty
    property p_restore;
        $fell(rst) |=> pu_en == $past(nv_pu_en)
            && range_on == ($past(nv_range_on) && $past(nv_pu_en));
    endproperty
    property p_span;
        dac_mv >= NEG_FS_MV && dac_mv <= FS_MV;
    endproperty
    property p_auto_clear;
        $fell(range_on) && !out_enabled |-> ##[0:3] dac_mv == 16'sh0;
    endproperty

    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_warm_off: assert property (p_warm_off)
        else $error("disabled output not at zero");
    a_cont_keep: assert property (p_cont_keep)
        else $error("range cleared in continuous control");
    a_range_set: assert property (p_range_set)
        else $error("range write did not take");
    a_mon_alloff: assert property (p_mon_alloff)
        else $error("monitor output disabled by all-off");
    a_restore: assert property (p_restore)
        else $error("power-up restore wrong");
    a_span: assert property (p_span)
        else $error("output outside span");
    a_auto_clear: assert property (p_auto_clear)
        else $error("auto-off left output driven");

    c_drive: cover property (range_on && dac_mv > 16'sh0);
    c_auto: cover property ($fell(range_on) && !out_enabled);
    c_neg: cover property (dac_mv == NEG_FS_MV);
endmodule : wmo_output_ctrl_monitor

bind wmo_output_ctrl wmo_output_ctrl_monitor i_mon (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reading(reading),
    .nv_range_on(nv_range_on), .nv_pu_en(nv_pu_en), .range_on(range_on),
    .pu_en(pu_en), .dac_mv(dac_mv), .out_enabled(out_enabled));
`default_nettype wire
